// >>> core/tscl_top.sv
// Top of the temperature sensor conversion and limit block with its APB register file.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
`include "tscl_consts.svh"
module tscl_top #(
  parameter int CONV_CYC       = `TSCL_CONV_CYC,
  parameter int FAST_CYC       = `TSCL_FAST_CYC,
  parameter int SPS_CONV_CYC   = `TSCL_SPS_CONV_CYC,
  parameter int SPS_PERIOD_CYC = `TSCL_SPS_PERIOD_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SENS_SCLK,
  input  wire logic        SENS_SDATA,
  input  wire logic        SENS_FRAME,
  input  wire logic        CRITICAL_OVERTEMP_OUTPUT_I,
  output logic             CRITICAL_OVERTEMP_OUTPUT_O,
  output logic             CRITICAL_OVERTEMP_OUTPUT_OE,
  input  wire logic        ALERT_I,
  output logic             ALERT_O,
  output logic             ALERT_OE,
  output logic             IRQ
);
  localparam int W = `TSCL_LINK_BITS;

  logic [7:0]   cfg_reg;
  logic [7:0]   cfg_next;
  logic [W-1:0] crit_reg;
  logic [W-1:0] crit_next;
  logic [W-1:0] high_reg;
  logic [W-1:0] high_next;
  logic [W-1:0] low_reg;
  logic [W-1:0] low_next;
  logic [3:0]   mask_reg;
  logic [3:0]   mask_next;
  logic [3:0]   sts_reg;
  logic [3:0]   sts_next;
  logic [W-1:0] raw_reg;
  logic [W-1:0] raw_next;
  logic [W-1:0] temp_reg;
  logic [W-1:0] temp_next;
  logic [2:0]   lvl_reg;
  logic [2:0]   lvl_next;
  logic [31:0]  prdata_reg;
  logic [31:0]  prdata_next;
  logic         pready_reg;
  logic         pready_next;
  logic         pslverr_reg;
  logic         pslverr_next;
  logic         crit_oe_reg;
  logic         crit_oe_next;
  logic         alert_oe_reg;
  logic         alert_oe_next;
  logic         irq_reg;
  logic         irq_next;

  logic                 conv_done;
  logic                 busy;
  logic [W-1:0]         link_word;
  logic                 link_valid;
  logic                 access;
  logic                 wr;
  logic                 mapped;
  logic                 oneshot_go;
  logic                 ev_mode;
  logic [2:0]           lvl_now;
  logic [3:0]           events;
  logic [W-4:0]         raw_hi;
  tscl_pkg::tscl_mode_t mode;

  function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
    hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : hit

  // Signed compare on the two's-complement result encoding.
  function automatic logic sgt(input logic [W-1:0] a, input logic [W-1:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction : sgt

  assign mode    = tscl_pkg::tscl_mode_t'(cfg_reg[`TSCL_CFG_MODE_MSB:`TSCL_CFG_MODE_LSB]);
  assign ev_mode = cfg_reg[`TSCL_CFG_EVMODE_BIT];
  assign raw_hi  = raw_reg[W-1:`TSCL_RES13_LSBS];
  assign access  = PSEL && PENABLE && pready_reg;
  assign wr      = access && PWRITE;
  assign mapped  = hit(PADDR, `TSCL_IDX_STATUS) || hit(PADDR, `TSCL_IDX_CONFIG) || hit(PADDR, `TSCL_IDX_TEMP)
                   || hit(PADDR, `TSCL_IDX_CRIT) || hit(PADDR, `TSCL_IDX_HIGH) || hit(PADDR, `TSCL_IDX_LOW)
                   || hit(PADDR, `TSCL_IDX_MASK);
  assign oneshot_go = wr && hit(PADDR, `TSCL_IDX_CONFIG)
                      && (PWDATA[`TSCL_CFG_MODE_MSB:`TSCL_CFG_MODE_LSB] == tscl_pkg::TSCL_MODE_ONESHOT);

  tscl_link_rx #(
    .W          (W)
  ) u_link_rx (
    .clk        (CLK),
    .rst_b      (RST_B),
    .sclk_pin   (SENS_SCLK),
    .sdata_pin  (SENS_SDATA),
    .frame_pin  (SENS_FRAME),
    .word       (link_word),
    .word_valid (link_valid)
  );

  tscl_seq #(
    .CONV_CYC       (CONV_CYC),
    .FAST_CYC       (FAST_CYC),
    .SPS_CONV_CYC   (SPS_CONV_CYC),
    .SPS_PERIOD_CYC (SPS_PERIOD_CYC)
  ) u_seq (
    .clk        (CLK),
    .rst_b      (RST_B),
    .mode       (mode),
    .oneshot_go (oneshot_go),
    .conv_done  (conv_done),
    .busy       (busy)
  );

  // Register file. Responses are prepared in the setup cycle so the access phase is one cycle long.
  always_comb begin
    cfg_next     = cfg_reg;
    crit_next    = crit_reg;
    high_next    = high_reg;
    low_next     = low_reg;
    mask_next    = mask_reg;
    pready_next  = PSEL && !PENABLE;
    pslverr_next = PSEL && !PENABLE && !mapped;
    prdata_next  = 32'h0;
    if (PSEL && !PENABLE && !PWRITE) begin
      if (hit(PADDR, `TSCL_IDX_STATUS)) begin
        prdata_next = {23'h0, busy, 4'h0, sts_reg};
      end else if (hit(PADDR, `TSCL_IDX_CONFIG)) begin
        prdata_next = {24'h0, cfg_reg};
      end else if (hit(PADDR, `TSCL_IDX_TEMP)) begin
        prdata_next = {16'h0, temp_reg};
      end else if (hit(PADDR, `TSCL_IDX_CRIT)) begin
        prdata_next = {16'h0, crit_reg};
      end else if (hit(PADDR, `TSCL_IDX_HIGH)) begin
        prdata_next = {16'h0, high_reg};
      end else if (hit(PADDR, `TSCL_IDX_LOW)) begin
        prdata_next = {16'h0, low_reg};
      end else if (hit(PADDR, `TSCL_IDX_MASK)) begin
        prdata_next = {28'h0, mask_reg};
      end
    end
    if (wr) begin
      if (hit(PADDR, `TSCL_IDX_CONFIG)) begin
        cfg_next = PWDATA[7:0];
      end
      if (hit(PADDR, `TSCL_IDX_CRIT)) begin
        crit_next = PWDATA[W-1:0];
      end
      if (hit(PADDR, `TSCL_IDX_HIGH)) begin
        high_next = PWDATA[W-1:0];
      end
      if (hit(PADDR, `TSCL_IDX_LOW)) begin
        low_next = PWDATA[W-1:0];
      end
      if (hit(PADDR, `TSCL_IDX_MASK)) begin
        mask_next = PWDATA[3:0];
      end
    end
  end

  // Result path and limit monitor.
  always_comb begin
    raw_next  = link_valid ? link_word : raw_reg;
    temp_next = temp_reg;
    if (conv_done) begin
      if (cfg_reg[`TSCL_CFG_RES_BIT]) begin
        temp_next = raw_reg;
      end else begin
        temp_next = {raw_hi, `TSCL_RES13_LSBS'(0)};
      end
    end
    lvl_now[0] = sgt(temp_reg, crit_reg);
    lvl_now[1] = sgt(temp_reg, high_reg);
    lvl_now[2] = sgt(low_reg, temp_reg);
    lvl_next   = lvl_now;
    events     = {lvl_now & ~lvl_reg, conv_done};
    // A new event wins over a write-one-to-clear in the same cycle.
    sts_next   = sts_reg;
    if (wr && hit(PADDR, `TSCL_IDX_STATUS)) begin
      sts_next = sts_reg & ~PWDATA[3:0];
    end
    sts_next = sts_next | events;
    if (ev_mode) begin
      crit_oe_next  = sts_reg[`TSCL_STS_CRIT];
      alert_oe_next = sts_reg[`TSCL_STS_HIGH] | sts_reg[`TSCL_STS_LOW];
    end else begin
      crit_oe_next  = lvl_now[0];
      alert_oe_next = lvl_now[1] | lvl_now[2];
    end
    irq_next = |(sts_reg & mask_reg);
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_reg      <= `TSCL_CFG_RST;
      crit_reg     <= `TSCL_CRIT_RST;
      high_reg     <= `TSCL_HIGH_RST;
      low_reg      <= `TSCL_LOW_RST;
      mask_reg     <= `TSCL_MASK_RST;
      sts_reg      <= 4'h0;
      raw_reg      <= 16'h0;
      temp_reg     <= 16'h0;
      lvl_reg      <= 3'h0;
      prdata_reg   <= 32'h0;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      crit_oe_reg  <= 1'b0;
      alert_oe_reg <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      cfg_reg      <= cfg_next;
      crit_reg     <= crit_next;
      high_reg     <= high_next;
      low_reg      <= low_next;
      mask_reg     <= mask_next;
      sts_reg      <= sts_next;
      raw_reg      <= raw_next;
      temp_reg     <= temp_next;
      lvl_reg      <= lvl_next;
      prdata_reg   <= prdata_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
      crit_oe_reg  <= crit_oe_next;
      alert_oe_reg <= alert_oe_next;
      irq_reg      <= irq_next;
    end
  end

  // Open-drain pins only ever pull low, so the data bits are constant zero and the enables are flip-flop outputs.
  assign PRDATA                      = prdata_reg;
  assign PREADY                      = pready_reg;
  assign PSLVERR                     = pslverr_reg;
  assign CRITICAL_OVERTEMP_OUTPUT_O  = 1'b0;
  assign CRITICAL_OVERTEMP_OUTPUT_OE = crit_oe_reg;
  assign ALERT_O                     = 1'b0;
  assign ALERT_OE                    = alert_oe_reg;
  assign IRQ                         = irq_reg;

  chk_res_default: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(RST_B) |-> (cfg_reg[`TSCL_CFG_RES_BIT] == 1'b0))
    else $error("Resolution is not 13 bits after reset.");

  chk_crit_default: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(RST_B) |-> (crit_reg == 16'h4980))
    else $error("Critical limit is not 147 degrees after reset.");

  chk_res_trunc: assert property (@(posedge CLK) disable iff (!RST_B)
    (conv_done && !cfg_reg[`TSCL_CFG_RES_BIT])
    |=> (temp_reg[2:0] == 3'h0 && temp_reg[W-1:3] == $past(raw_hi)))
    else $error("13-bit result is not the sign and 12 magnitude bits.");

  chk_res_full: assert property (@(posedge CLK) disable iff (!RST_B)
    (conv_done && cfg_reg[`TSCL_CFG_RES_BIT]) |=> (temp_reg == $past(raw_reg)))
    else $error("16-bit result does not carry the full sample.");

  chk_temp_hold: assert property (@(posedge CLK) disable iff (!RST_B)
    !conv_done |=> $stable(temp_reg))
    else $error("Result changed without a completed conversion.");

  chk_crit_level: assert property (@(posedge CLK) disable iff (!RST_B)
    (!ev_mode && sgt(temp_reg, crit_reg)) |=> CRITICAL_OVERTEMP_OUTPUT_OE)
    else $error("Critical output not asserted above the critical limit.");

  chk_alert_level: assert property (@(posedge CLK) disable iff (!RST_B)
    (!ev_mode && (sgt(temp_reg, high_reg) || sgt(low_reg, temp_reg))) |=> ALERT_OE)
    else $error("Alert output not asserted outside the limits.");

  chk_alert_event: assert property (@(posedge CLK) disable iff (!RST_B)
    (ev_mode && events[`TSCL_STS_HIGH] ##1 ev_mode) |=> ALERT_OE)
    else $error("Alert output did not latch an over-limit event.");
endmodule : tscl_top

// >>> core/tscl_consts.svh
// Constants of the temperature sensor conversion and limit block.
// Behaviour
// - Power-up default result resolution is 13 bits.
// - Configuration bit 7 selects 16-bit results.
// - Results are two's complement, sign plus magnitude.
// - Critical output asserts above critical limit.
// - Critical limit resets to 147 degrees Celsius.
// - Alert output flags over and under limits.
// - Outputs work as comparator or interrupt.
// - Continuous and one-shot conversions take 240 ms.
// - Only first conversion after reset takes 6 ms. Code also gives 6 ms to the next one if shutdown cuts the first short.
// - Samples-per-second mode converts 60 ms each second.
// - Shutdown mode stops all conversion activity.
`ifndef TSCL_CONSTS_SVH
`define TSCL_CONSTS_SVH

`define TSCL_CLK_HZ           50000000
`define TSCL_CYC_PER_MS       (`TSCL_CLK_HZ / 1000)
`define TSCL_T_CONV_MS        240
`define TSCL_T_FAST_MS        6
`define TSCL_T_SPS_CONV_MS    60
`define TSCL_T_SPS_PERIOD_MS  1000
`define TSCL_CONV_CYC         (`TSCL_CYC_PER_MS * `TSCL_T_CONV_MS)
`define TSCL_FAST_CYC         (`TSCL_CYC_PER_MS * `TSCL_T_FAST_MS)
`define TSCL_SPS_CONV_CYC     (`TSCL_CYC_PER_MS * `TSCL_T_SPS_CONV_MS)
`define TSCL_SPS_PERIOD_CYC   (`TSCL_CYC_PER_MS * `TSCL_T_SPS_PERIOD_MS)
`define TSCL_CNT_W            26

`define TSCL_IDX_STATUS       6'h00
`define TSCL_IDX_CONFIG       6'h01
`define TSCL_IDX_TEMP         6'h02
`define TSCL_IDX_CRIT         6'h03
`define TSCL_IDX_HIGH         6'h04
`define TSCL_IDX_LOW          6'h05
`define TSCL_IDX_MASK         6'h06

`define TSCL_CFG_RES_BIT      7
`define TSCL_CFG_MODE_MSB     6
`define TSCL_CFG_MODE_LSB     5
`define TSCL_CFG_EVMODE_BIT   4
`define TSCL_STS_DONE         0
`define TSCL_STS_CRIT         1
`define TSCL_STS_HIGH         2
`define TSCL_STS_LOW          3
`define TSCL_STS_BUSY         8

`define TSCL_CFG_RST          8'h00
`define TSCL_CRIT_RST         16'h4980
`define TSCL_HIGH_RST         16'h2000
`define TSCL_LOW_RST          16'h0500
`define TSCL_MASK_RST         4'h0
`define TSCL_LINK_BITS        16
`define TSCL_RES13_LSBS       3

`endif

// >>> core/tscl_pkg.sv
// Types shared by the temperature sensor conversion and limit block.
package tscl_pkg;
  typedef enum logic [1:0] {
    TSCL_MODE_CONT               = 2'b00,
    TSCL_MODE_ONESHOT            = 2'b01,
    TSCL_MODE_SAMPLES_PER_SECOND = 2'b10,
    TSCL_MODE_SHUTDOWN           = 2'b11
  } tscl_mode_t;

  typedef enum logic [1:0] {
    TSCL_SEQ_IDLE = 2'b00,
    TSCL_SEQ_CONV = 2'b01,
    TSCL_SEQ_REST = 2'b10
  } tscl_seq_state_t;
endpackage : tscl_pkg

// >>> core/tscl_link_rx.sv
// Receiver for the serial sample word from the sensing front end.
`timescale 1ns/1ns
`include "tscl_consts.svh"
module tscl_link_rx #(
  parameter int W = `TSCL_LINK_BITS
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         sclk_pin,
  input  wire logic         sdata_pin,
  input  wire logic         frame_pin,
  output logic [W-1:0]      word,
  output logic              word_valid
);
  localparam int CW = $clog2(W + 1);

  logic [2:0]    sync1_reg;
  logic [2:0]    sync2_reg;
  logic          sclk_prev_reg;
  logic          frame_prev_reg;
  logic [W-1:0]  shift_reg;
  logic [W-1:0]  shift_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [W-1:0]  word_reg;
  logic [W-1:0]  word_next;
  logic          valid_reg;
  logic          valid_next;
  logic          sclk_s;
  logic          sdata_s;
  logic          frame_s;

  assign sclk_s  = sync2_reg[2];
  assign sdata_s = sync2_reg[1];
  assign frame_s = sync2_reg[0];

  // A frame that carries fewer than W bits is dropped rather than half used; bits past the W-th are ignored.
  always_comb begin
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    word_next  = word_reg;
    valid_next = 1'b0;
    if (frame_s && !frame_prev_reg) begin
      cnt_next = '0;
    end else if (frame_s && sclk_s && !sclk_prev_reg && cnt_reg < CW'(W)) begin
      shift_next = {shift_reg[W-2:0], sdata_s};
      cnt_next   = CW'(cnt_reg + 1'b1);
    end
    if (!frame_s && frame_prev_reg && cnt_reg == CW'(W)) begin
      word_next  = shift_reg;
      valid_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg      <= 3'h0;
      sync2_reg      <= 3'h0;
      sclk_prev_reg  <= 1'b0;
      frame_prev_reg <= 1'b0;
      shift_reg      <= '0;
      cnt_reg        <= '0;
      word_reg       <= '0;
      valid_reg      <= 1'b0;
    end else begin
      sync1_reg      <= {sclk_pin, sdata_pin, frame_pin};
      sync2_reg      <= sync1_reg;
      sclk_prev_reg  <= sclk_s;
      frame_prev_reg <= frame_s;
      shift_reg      <= shift_next;
      cnt_reg        <= cnt_next;
      word_reg       <= word_next;
      valid_reg      <= valid_next;
    end
  end

  assign word       = word_reg;
  assign word_valid = valid_reg;
endmodule : tscl_link_rx

// >>> core/tscl_seq.sv
// Conversion sequencer: mode handling and conversion timing.
`timescale 1ns/1ns
`include "tscl_consts.svh"
module tscl_seq #(
  parameter int CONV_CYC       = `TSCL_CONV_CYC,
  parameter int FAST_CYC       = `TSCL_FAST_CYC,
  parameter int SPS_CONV_CYC   = `TSCL_SPS_CONV_CYC,
  parameter int SPS_PERIOD_CYC = `TSCL_SPS_PERIOD_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  tscl_pkg::tscl_mode_t     mode,
  input  wire logic                oneshot_go,
  output logic                     conv_done,
  output logic                     busy
);
  localparam int CNT_W = `TSCL_CNT_W;

  tscl_pkg::tscl_seq_state_t state_reg;
  tscl_pkg::tscl_seq_state_t state_next;
  logic [CNT_W-1:0]          cnt_reg;
  logic [CNT_W-1:0]          cnt_next;
  logic                      first_reg;
  logic                      first_next;
  logic                      done_reg;
  logic                      done_next;

  function automatic logic [CNT_W-1:0] load_for(input tscl_pkg::tscl_mode_t m, input logic first);
    if (first) begin
      load_for = CNT_W'(FAST_CYC - 1);
    end else if (m == tscl_pkg::TSCL_MODE_SAMPLES_PER_SECOND) begin
      load_for = CNT_W'(SPS_CONV_CYC - 1);
    end else begin
      load_for = CNT_W'(CONV_CYC - 1);
    end
  endfunction : load_for

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    first_next = first_reg;
    done_next  = 1'b0;
    unique case (state_reg)
      tscl_pkg::TSCL_SEQ_IDLE: begin
        if (mode == tscl_pkg::TSCL_MODE_CONT || mode == tscl_pkg::TSCL_MODE_SAMPLES_PER_SECOND || oneshot_go) begin
          state_next = tscl_pkg::TSCL_SEQ_CONV;
          cnt_next   = load_for(mode, first_reg);
        end
      end
      tscl_pkg::TSCL_SEQ_CONV: begin
        if (mode == tscl_pkg::TSCL_MODE_SHUTDOWN) begin
          state_next = tscl_pkg::TSCL_SEQ_IDLE;
        end else if (cnt_reg == '0) begin
          done_next  = 1'b1;
          first_next = 1'b0;
          if (mode == tscl_pkg::TSCL_MODE_CONT) begin
            cnt_next = load_for(mode, 1'b0);
          end else if (mode == tscl_pkg::TSCL_MODE_SAMPLES_PER_SECOND) begin
            state_next = tscl_pkg::TSCL_SEQ_REST;
            cnt_next   = CNT_W'(SPS_PERIOD_CYC - SPS_CONV_CYC - 1);
          end else begin
            state_next = tscl_pkg::TSCL_SEQ_IDLE;
          end
        end else begin
          cnt_next = CNT_W'(cnt_reg - 1'b1);
        end
      end
      tscl_pkg::TSCL_SEQ_REST: begin
        if (mode != tscl_pkg::TSCL_MODE_SAMPLES_PER_SECOND) begin
          state_next = tscl_pkg::TSCL_SEQ_IDLE;
        end else if (cnt_reg == '0) begin
          state_next = tscl_pkg::TSCL_SEQ_CONV;
          cnt_next   = load_for(mode, first_reg);
        end else begin
          cnt_next = CNT_W'(cnt_reg - 1'b1);
        end
      end
      default: begin
        state_next = tscl_pkg::TSCL_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= tscl_pkg::TSCL_SEQ_IDLE;
      cnt_reg   <= '0;
      first_reg <= 1'b1;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      first_reg <= first_next;
      done_reg  <= done_next;
    end
  end

  assign conv_done = done_reg;
  assign busy      = (state_reg == tscl_pkg::TSCL_SEQ_CONV);

  chk_first_fast: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == tscl_pkg::TSCL_SEQ_IDLE && state_next == tscl_pkg::TSCL_SEQ_CONV && first_reg)
    |=> (cnt_reg == CNT_W'(FAST_CYC - 1)))
    else $error("First conversion is not loaded with the fast time.");

  chk_conv_reload: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == tscl_pkg::TSCL_SEQ_CONV && cnt_reg == '0 && mode == tscl_pkg::TSCL_MODE_CONT)
    |=> (state_reg == tscl_pkg::TSCL_SEQ_CONV && cnt_reg == CNT_W'(CONV_CYC - 1) && conv_done))
    else $error("Continuous conversion did not restart with the normal time.");

  chk_sps_rest: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == tscl_pkg::TSCL_SEQ_CONV && cnt_reg == '0 && mode == tscl_pkg::TSCL_MODE_SAMPLES_PER_SECOND)
    |=> (state_reg == tscl_pkg::TSCL_SEQ_REST && cnt_reg == CNT_W'(SPS_PERIOD_CYC - SPS_CONV_CYC - 1)))
    else $error("Rest period after a sample is wrong.");

  chk_sps_conv: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == tscl_pkg::TSCL_SEQ_REST && cnt_reg == '0 && mode == tscl_pkg::TSCL_MODE_SAMPLES_PER_SECOND
     && !first_reg)
    |=> (state_reg == tscl_pkg::TSCL_SEQ_CONV && cnt_reg == CNT_W'(SPS_CONV_CYC - 1)))
    else $error("Sample conversion is not loaded with its own time.");

  chk_shutdown_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    (mode == tscl_pkg::TSCL_MODE_SHUTDOWN && state_reg != tscl_pkg::TSCL_SEQ_IDLE)
    |=> (!conv_done && state_reg == tscl_pkg::TSCL_SEQ_IDLE))
    else $error("Conversion continued in shutdown.");
endmodule : tscl_seq

// >>> tb/tscl_front_model.sv
// Behavioural sensing front end that shifts sample words into the link.
`timescale 1ns/1ns
module tscl_front_model (
  output logic sclk,
  output logic sdata,
  output logic frame
);
  logic idle_tg;

  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    frame = 1'b0;
    idle_tg = 1'b0;
  end

  // Outside a frame the data line toggles, so no stale bit can pass for a real one.
  always #80 if (!frame) begin
    idle_tg = ~idle_tg;
    sdata = idle_tg;
  end

  // The link clock stands low between frames and runs at 160 ns inside them.
  task automatic send(input logic [15:0] w);
    frame = 1'b1;
    #100;
    for (int i = 15; i >= 0; i--) begin
      sdata = w[i];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #40 frame = 1'b0;
  endtask : send
endmodule : tscl_front_model

// >>> tb/test_tscl_top.sv
// Self-checking bench of the temperature conversion and limit block.
`timescale 1ns/1ns
module test_tscl_top;
  localparam int CONV = 40, FAST = 10, SPSC = 20, SPSP = 100;
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, sclk, sdata, frame, crit_oe, alert_oe, irq, co, ao;
  logic [15:0] t;
  logic [7:0]  cfg = 8'h00;
  logic [7:0]  ra [5] = '{8'h04, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv [5] = '{32'h0, 32'h4980, 32'h2000, 32'h0500, 32'h0};
  int          err_total = 0, checked = 0, cyc = 0, dt;
  int unsigned seed = 52;
  int          sent[$];

  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  tscl_front_model FE (.sclk(sclk), .sdata(sdata), .frame(frame));

  tscl_top #(.CONV_CYC(CONV), .FAST_CYC(FAST), .SPS_CONV_CYC(SPSC), .SPS_PERIOD_CYC(SPSP)) DUT (
    .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SENS_SCLK(sclk),
    .SENS_SDATA(sdata), .SENS_FRAME(frame), .CRITICAL_OVERTEMP_OUTPUT_I(~crit_oe),
    .CRITICAL_OVERTEMP_OUTPUT_O(co), .CRITICAL_OVERTEMP_OUTPUT_OE(crit_oe), .ALERT_I(~alert_oe),
    .ALERT_O(ao), .ALERT_OE(alert_oe), .IRQ(irq));

  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs

  // In 13-bit resolution the three lowest bits of the result read as zero.
  function automatic logic [15:0] exp_t(input int w, input logic r16);
    return r16 ? w[15:0] : {w[15:3], 3'h0};
  endfunction : exp_t

  task automatic stop_test();
    $display("errors=%0d checks=%0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin err_total++; stop_test(); end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Polls the done flag, then clears it; dt is the wait in clock cycles.
  task automatic wait_done(output int d);
    int c0;
    c0 = cyc;
    q = 32'h0;
    for (int i = 0; i < 400 && q[0] !== 1'b1; i++) apb(1'b0, 8'h00, 32'h0);
    if (q[0] !== 1'b1) begin err_total++; stop_test(); end
    d = cyc - c0;
    apb(1'b1, 8'h00, 32'h1);
  endtask : wait_done

  task automatic pin_chk(input int which, input logic x);
    repeat (3) @(posedge clk);
    chk({31'h0, which ? alert_oe : crit_oe}, {31'h0, x});
  endtask : pin_chk

  initial begin
    logic [15:0] w;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    wait_done(dt); chk(dt <= FAST + 7, 1);
    wait_done(dt); chk(dt >= CONV - 8 && dt <= CONV + 4, 1);
    foreach (ra[i]) begin apb(1'b0, ra[i], 32'h0); chk(q, rv[i]); end
    apb(1'b0, 8'h1c, 32'h0); chk({31'h0, e}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) begin cfg[7] = 1'b1; apb(1'b1, 8'h04, {24'h0, cfg}); end
      w = xs() | 16'h0008;
      w[15] = (k == 1 || k == 2);
      sent.push_back(w);
      FE.send(w);
      repeat (6) @(posedge clk);
      wait_done(dt);
      wait_done(dt);
      apb(1'b0, 8'h08, 32'h0); chk(q, {16'h0, exp_t(sent[$], cfg[7])});
    end
    t = exp_t(sent[$], cfg[7]);
    apb(1'b1, 8'h0c, {16'h0, t - 16'h8}); pin_chk(0, 1);
    apb(1'b1, 8'h0c, {16'h0, t}); pin_chk(0, 0);
    apb(1'b1, 8'h10, {16'h0, t - 16'h8}); pin_chk(1, 1);
    apb(1'b1, 8'h10, 32'h7fff); apb(1'b1, 8'h14, {16'h0, t + 16'h8}); pin_chk(1, 1);
    apb(1'b1, 8'h14, 32'h0); pin_chk(1, 0);
    // The comparator checks left sticky events behind, so interrupt mode starts with the crit, high and low flags cleared.
    apb(1'b1, 8'h00, 32'he);
    cfg[4] = 1'b1; apb(1'b1, 8'h04, {24'h0, cfg}); apb(1'b1, 8'h18, 32'h4);
    apb(1'b1, 8'h0c, {16'h0, t - 16'h8}); pin_chk(0, 1); chk({31'h0, irq}, 0);
    apb(1'b1, 8'h10, {16'h0, t - 16'h8}); apb(1'b1, 8'h10, 32'h7fff); pin_chk(1, 1);
    chk({31'h0, irq}, 1);
    apb(1'b0, 8'h00, 32'h0); chk({30'h0, q[2:1]}, 32'h3);
    apb(1'b1, 8'h0c, 32'h7fff); apb(1'b1, 8'h00, 32'he); pin_chk(1, 0); pin_chk(0, 0);
    chk({31'h0, irq}, 0);
    cfg[6:5] = 2'b11; apb(1'b1, 8'h04, {24'h0, cfg});
    repeat (2 * CONV) @(posedge clk);
    apb(1'b1, 8'h00, 32'h1);
    repeat (2 * CONV) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0); chk({31'h0, q[8]}, 0); chk({31'h0, q[0]}, 0);
    cfg[6:5] = 2'b01; apb(1'b1, 8'h04, {24'h0, cfg});
    wait_done(dt); chk(dt >= CONV - 2 && dt <= CONV + 8, 1);
    repeat (2 * CONV) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0); chk({31'h0, q[0]}, 0);
    cfg[6:5] = 2'b10; apb(1'b1, 8'h04, {24'h0, cfg});
    wait_done(dt);
    wait_done(dt); chk(dt >= SPSP - 8 && dt <= SPSP + 4, 1);
    apb(1'b0, 8'h00, 32'h0); chk({31'h0, q[8]}, 0);
    chk({30'h0, co, ao}, 32'h0);
    stop_test();
  end
endmodule : test_tscl_top
